/* File: design/tmr_pkg.sv */
// package: register map, field positions, reset values and mode codes of the dual timer
`default_nettype none
package tmr_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h88;
  localparam logic [7:0] ADDR_MODE    = 8'h89;
  localparam logic [7:0] ADDR_CNT0_LO = 8'h8a;
  localparam logic [7:0] ADDR_CNT1_LO = 8'h8b;
  localparam logic [7:0] ADDR_CNT0_HI = 8'h8c;
  localparam logic [7:0] ADDR_CNT1_HI = 8'h8d;
  localparam logic [7:0] ADDR_CTRL_B  = 8'h91;
  localparam logic [7:0] ADDR_RLD0_LO = 8'hf2;
  localparam logic [7:0] ADDR_RLD1_LO = 8'hf3;
  localparam logic [7:0] ADDR_RLD0_HI = 8'hf4;
  localparam logic [7:0] ADDR_RLD1_HI = 8'hf5;
  localparam logic [7:0] ADDR_CLK_CTL = 8'h8f;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_CTRL_B   = 8'h24;
  localparam logic [7:0] RST_CLK_CTL  = 8'h05;
  localparam logic [7:0] RST_CNT      = 8'h00;
  localparam logic [7:0] RST_RLD      = 8'h00;
  // timer_control bit positions
  localparam int BIT_OVF1  = 7;
  localparam int BIT_RUN1  = 6;
  localparam int BIT_OVF0  = 5;
  localparam int BIT_RUN0  = 4;
  localparam int BIT_EDG1  = 3;
  localparam int BIT_TYP1  = 2;
  localparam int BIT_EDG0  = 1;
  localparam int BIT_TYP0  = 0;
  // clock_ctrl_reg: [3:0] shared divider, [4] fast mode, [5] dbl0, [6] dbl1
  localparam int BIT_FAST  = 4;
  localparam int BIT_DBL0  = 5;
  typedef enum logic [1:0] {
    MODE_VAR  = 2'b00,
    MODE_R16  = 2'b01,
    MODE_R8   = 2'b10,
    MODE_SPLT = 2'b11
  } tmode_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] ctrl_b;
    logic [7:0] clk_ctl;
    logic [1:0][7:0] cnt_lo;
    logic [1:0][7:0] cnt_hi;
    logic [1:0][7:0] rld_lo;
    logic [1:0][7:0] rld_hi;
    logic [3:0] div_cnt;
    logic       half_ph;
    logic [1:0] pin_prev;
    logic [1:0] irq_prev;
    logic [7:0] rdata;
  } tmr_state_t;
endpackage : tmr_pkg
`default_nettype wire

/* File: design/dual_timer.sv */
// dual 16-bit timer/counter with four modes, register port and pin sampling
//
// Chosen here: the strobed register port.
`default_nettype none
// What this block does
// - overflow sets flag; interrupt acknowledge clears it
// - run bit switches each timer
// - falling edge on irq pin sets flag
// - type bit picks edge or low level
// - count needs run and gate low or pin high
// - select bit picks clock or pin events
// - two mode bits pick four modes
// - mode 0 low byte prescales psc+1 bits
// - prescale width resets to 100b
// - mode 0 rollover sets overflow flag
// - setting run keeps count
// - mode 1 reloads from reload pair
// - reload pair resets to zero
// - mode 2 reloads low from high
// - timer 1 mode 3 holds count
// - split mode high byte uses timer1 controls
// - timer 1 silent while timer 0 split
// - reload pair idle for counting in modes 0,2,3; rld_hi sets pin compare in every mode
// - pulse enable drives count pin
// - shared divider plus one, double-speed rules
// - pin high then low counts once
// - compatibility divider defaults to five
module dual_timer (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] irq_ack,
  input  wire logic [1:0] ext_irq_pin,
  input  wire logic [1:0] count_pin_in,
  output logic      [1:0] count_pin_out,
  output logic      [1:0] count_pin_oe_n,
  output logic      [1:0] ext_irq_req
);

  // ********************************
  // pin synchronisers
  // ********************************
  logic [1:0] cnt_meta_r;
  logic [1:0] cnt_sync_r;
  logic [1:0] irq_meta_r;
  logic [1:0] irq_sync_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_meta_r <= 2'h3;
      cnt_sync_r <= 2'h3;
      irq_meta_r <= 2'h3;
      irq_sync_r <= 2'h3;
    end else begin
      cnt_meta_r <= count_pin_in;
      cnt_sync_r <= cnt_meta_r;
      irq_meta_r <= ext_irq_pin;
      irq_sync_r <= irq_meta_r;
    end
  end

  // ********************************
  // state
  // ********************************
  tmr_pkg::tmr_state_t st_r;
  tmr_pkg::tmr_state_t st_nxt;

  logic       base_tick;
  logic [1:0] tick;
  logic [1:0] run_ok;
  logic [1:0] fall;
  logic [1:0] inc;
  logic [1:0] ovf;
  logic       hi_split_inc;
  logic       split0;
  logic       pwm_out0;
  logic       pwm_out1;

  always_comb begin
    logic [15:0] c16;
    logic [8:0]  lo9;
    logic [8:0]  hi9;
    logic [7:0]  lmask;
    logic        lo_wrap;
    tmr_pkg::tmode_t md;
    c16 = 16'h0000;
    lo9 = 9'h000;
    hi9 = 9'h000;
    lmask = 8'h00;
    lo_wrap = 1'b0;
    md = tmr_pkg::MODE_VAR;
    st_nxt = st_r;
    ovf = 2'b00;
    hi_split_inc = 1'b0;
    split0 = (st_r.mode[1:0] == tmr_pkg::MODE_SPLT);

    // shared divider: a slow tick every divider+1 clocks
    // greater-or-equal: a smaller divider written mid-count must not wait for a wrap
    base_tick = (st_r.div_cnt >= st_r.clk_ctl[3:0]);
    st_nxt.div_cnt = base_tick ? 4'h0 : st_r.div_cnt + 4'h1;
    if (base_tick) begin
      st_nxt.half_ph = ~st_r.half_ph;
    end

    for (int n = 0; n < 2; n++) begin
      // fast mode: divider only with double-speed; compat: always, double halves
      if (st_r.clk_ctl[tmr_pkg::BIT_FAST]) begin
        tick[n] = st_r.clk_ctl[tmr_pkg::BIT_DBL0 + n] ? base_tick : 1'b1;
      end else begin
        tick[n] = base_tick & (~st_r.clk_ctl[tmr_pkg::BIT_DBL0 + n] | st_r.half_ph);
      end
      // pin sampled on each tick; a 1 then 0 pair is one event
      fall[n] = st_r.pin_prev[n] & ~cnt_sync_r[n];
      if (tick[n]) begin
        st_nxt.pin_prev[n] = cnt_sync_r[n];
      end
      run_ok[n] = st_r.ctrl[tmr_pkg::BIT_RUN0 + 2 * n]
                & (~st_r.mode[3 + 4 * n] | irq_sync_r[n]);
      inc[n] = run_ok[n] & tick[n]
             & (st_r.mode[2 + 4 * n] ? fall[n] : 1'b1);
    end

    // timer 1 in mode 3 simply holds
    if (st_r.mode[5:4] == tmr_pkg::MODE_SPLT) begin
      inc[1] = 1'b0;
    end

    for (int n = 0; n < 2; n++) begin
      md = tmr_pkg::tmode_t'(st_r.mode[4 * n +: 2]);
      case (md)
        tmr_pkg::MODE_VAR: begin
          // low byte keeps psc+1 bits; upper bits are cleared on each count
          lmask = 8'hff >> (3'h7 - st_r.ctrl_b[3 * n +: 3]);
          if (inc[n]) begin
            lo_wrap = ((st_r.cnt_lo[n] & lmask) == lmask);
            st_nxt.cnt_lo[n] = (st_r.cnt_lo[n] + 8'h01) & lmask;
            if (lo_wrap) begin
              hi9 = {1'b0, st_r.cnt_hi[n]} + 9'h001;
              st_nxt.cnt_hi[n] = hi9[7:0];
              ovf[n] = hi9[8];
            end
          end
        end
        tmr_pkg::MODE_R16: begin
          if (inc[n]) begin
            c16 = {st_r.cnt_hi[n], st_r.cnt_lo[n]};
            if (c16 == 16'hffff) begin
              // reload pair feeds the count only here; rld_hi also sets the count pin compare
              st_nxt.cnt_hi[n] = st_r.rld_hi[n];
              st_nxt.cnt_lo[n] = st_r.rld_lo[n];
              ovf[n] = 1'b1;
            end else begin
              c16 = c16 + 16'h0001;
              st_nxt.cnt_hi[n] = c16[15:8];
              st_nxt.cnt_lo[n] = c16[7:0];
            end
          end
        end
        tmr_pkg::MODE_R8: begin
          if (inc[n]) begin
            lo9 = {1'b0, st_r.cnt_lo[n]} + 9'h001;
            st_nxt.cnt_lo[n] = lo9[8] ? st_r.cnt_hi[n] : lo9[7:0];
            ovf[n] = lo9[8];
          end
        end
        tmr_pkg::MODE_SPLT: begin
          // only timer 0 lands here with counting; low byte alone
          if (inc[n]) begin
            lo9 = {1'b0, st_r.cnt_lo[n]} + 9'h001;
            st_nxt.cnt_lo[n] = lo9[7:0];
            ovf[n] = lo9[8];
          end
        end
        default: begin
          ovf[n] = 1'b0;
        end
      endcase
    end

    // split mode: timer 0 high byte counts clocks under timer 1 run bit
    if (split0) begin
      hi_split_inc = st_r.ctrl[tmr_pkg::BIT_RUN1] & tick[0];
      ovf[1] = 1'b0;
      if (hi_split_inc) begin
        hi9 = {1'b0, st_r.cnt_hi[0]} + 9'h001;
        st_nxt.cnt_hi[0] = hi9[7:0];
        ovf[1] = hi9[8];
      end
    end

    // flags: set beats acknowledge
    for (int n = 0; n < 2; n++) begin
      if (irq_ack[n]) begin
        st_nxt.ctrl[tmr_pkg::BIT_OVF0 + 2 * n] = 1'b0;
      end
      if (ovf[n]) begin
        st_nxt.ctrl[tmr_pkg::BIT_OVF0 + 2 * n] = 1'b1;
      end
      st_nxt.irq_prev[n] = irq_sync_r[n];
      if (st_r.ctrl[tmr_pkg::BIT_TYP0 + 2 * n]) begin
        if (st_r.irq_prev[n] & ~irq_sync_r[n]) begin
          st_nxt.ctrl[tmr_pkg::BIT_EDG0 + 2 * n] = 1'b1;
        end else if (irq_ack[n]) begin
          st_nxt.ctrl[tmr_pkg::BIT_EDG0 + 2 * n] = 1'b0;
        end
      end else begin
        // level mode: flag follows the pin low
        st_nxt.ctrl[tmr_pkg::BIT_EDG0 + 2 * n] = ~irq_sync_r[n];
      end
    end

    // software access wins over hardware updates
    st_nxt.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        tmr_pkg::ADDR_CTRL:    st_nxt.ctrl = reg_wdata;
        tmr_pkg::ADDR_MODE:    st_nxt.mode = reg_wdata;
        tmr_pkg::ADDR_CNT0_LO: st_nxt.cnt_lo[0] = reg_wdata;
        tmr_pkg::ADDR_CNT1_LO: st_nxt.cnt_lo[1] = reg_wdata;
        tmr_pkg::ADDR_CNT0_HI: st_nxt.cnt_hi[0] = reg_wdata;
        tmr_pkg::ADDR_CNT1_HI: st_nxt.cnt_hi[1] = reg_wdata;
        tmr_pkg::ADDR_CTRL_B:  st_nxt.ctrl_b = reg_wdata;
        tmr_pkg::ADDR_RLD0_LO: st_nxt.rld_lo[0] = reg_wdata;
        tmr_pkg::ADDR_RLD1_LO: st_nxt.rld_lo[1] = reg_wdata;
        tmr_pkg::ADDR_RLD0_HI: st_nxt.rld_hi[0] = reg_wdata;
        tmr_pkg::ADDR_RLD1_HI: st_nxt.rld_hi[1] = reg_wdata;
        tmr_pkg::ADDR_CLK_CTL: st_nxt.clk_ctl = {1'b0, reg_wdata[6:0]};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        tmr_pkg::ADDR_CTRL:    st_nxt.rdata = st_r.ctrl;
        tmr_pkg::ADDR_MODE:    st_nxt.rdata = st_r.mode;
        tmr_pkg::ADDR_CNT0_LO: st_nxt.rdata = st_r.cnt_lo[0];
        tmr_pkg::ADDR_CNT1_LO: st_nxt.rdata = st_r.cnt_lo[1];
        tmr_pkg::ADDR_CNT0_HI: st_nxt.rdata = st_r.cnt_hi[0];
        tmr_pkg::ADDR_CNT1_HI: st_nxt.rdata = st_r.cnt_hi[1];
        tmr_pkg::ADDR_CTRL_B:  st_nxt.rdata = st_r.ctrl_b;
        tmr_pkg::ADDR_RLD0_LO: st_nxt.rdata = st_r.rld_lo[0];
        tmr_pkg::ADDR_RLD1_LO: st_nxt.rdata = st_r.rld_lo[1];
        tmr_pkg::ADDR_RLD0_HI: st_nxt.rdata = st_r.rld_hi[0];
        tmr_pkg::ADDR_RLD1_HI: st_nxt.rdata = st_r.rld_hi[1];
        tmr_pkg::ADDR_CLK_CTL: st_nxt.rdata = st_r.clk_ctl;
        default:               st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r.ctrl     <= tmr_pkg::RST_CTRL;
      st_r.mode     <= tmr_pkg::RST_MODE;
      st_r.ctrl_b   <= tmr_pkg::RST_CTRL_B;
      st_r.clk_ctl  <= tmr_pkg::RST_CLK_CTL;
      st_r.cnt_lo   <= {2{tmr_pkg::RST_CNT}};
      st_r.cnt_hi   <= {2{tmr_pkg::RST_CNT}};
      st_r.rld_lo   <= {2{tmr_pkg::RST_RLD}};
      st_r.rld_hi   <= {2{tmr_pkg::RST_RLD}};
      st_r.div_cnt  <= 4'h0;
      st_r.half_ph  <= 1'b0;
      st_r.pin_prev <= 2'h3;
      st_r.irq_prev <= 2'h3;
      st_r.rdata    <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************
  // outputs
  // ********************************
  // simple compare against the high-byte reload; waveform detail is kept minimal
  assign pwm_out0 = (st_r.cnt_hi[0] < st_r.rld_hi[0]);
  assign pwm_out1 = (st_r.cnt_hi[1] < st_r.rld_hi[1]);
  assign reg_rdata = st_r.rdata;
  assign count_pin_out = {pwm_out1, pwm_out0};
  assign count_pin_oe_n = ~st_r.ctrl_b[7:6];
  assign ext_irq_req = {st_r.ctrl[tmr_pkg::BIT_EDG1], st_r.ctrl[tmr_pkg::BIT_EDG0]};

  // ********************************
  // assertions
  // ********************************
  a_ovf_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ovf[0] && !reg_wr) |=> st_r.ctrl[tmr_pkg::BIT_OVF0])
    else $error("timer 0 overflow did not set flag");
  a_stopped_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!st_r.ctrl[tmr_pkg::BIT_RUN1] && !reg_wr) |=> $stable(st_r.cnt_lo[1]))
    else $error("stopped timer 1 changed count");
  a_edge_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.ctrl[tmr_pkg::BIT_TYP0] && st_r.irq_prev[0] && !irq_sync_r[0] && !reg_wr)
    |=> st_r.ctrl[tmr_pkg::BIT_EDG0])
    else $error("edge flag not set");
  a_gate_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[3] && !irq_sync_r[0]) |-> !inc[0])
    else $error("gated timer 0 counted");
  a_r16_reload: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[1:0] == 2'b01 && inc[0] && {st_r.cnt_hi[0], st_r.cnt_lo[0]} == 16'hffff
     && !reg_wr) |=> (st_r.cnt_lo[0] == $past(st_r.rld_lo[0])))
    else $error("mode 1 reload missing");
  a_r8_reload: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[1:0] == 2'b10 && inc[0] && st_r.cnt_lo[0] == 8'hff && !reg_wr)
    |=> (st_r.cnt_lo[0] == st_r.cnt_hi[0]) && $stable(st_r.cnt_hi[0]))
    else $error("mode 2 reload wrong");
  a_t1_split_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[5:4] == 2'b11 && !reg_wr) |=> $stable(st_r.cnt_hi[1]))
    else $error("timer 1 mode 3 moved");
  a_read_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_rd && reg_addr == tmr_pkg::ADDR_MODE) |=> reg_rdata == $past(st_r.mode))
    else $error("read data wrong");
  a_ovf1_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ovf[1] && !reg_wr) |=> st_r.ctrl[tmr_pkg::BIT_OVF1])
    else $error("timer 1 overflow did not set flag");
  a_ack_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (irq_ack[0] && !ovf[0] && !reg_wr) |=> !st_r.ctrl[tmr_pkg::BIT_OVF0])
    else $error("acknowledge did not clear timer 0 flag");
  a_level_mirror: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!st_r.ctrl[tmr_pkg::BIT_TYP0] && !reg_wr)
    |=> (st_r.ctrl[tmr_pkg::BIT_EDG0] == !$past(irq_sync_r[0])))
    else $error("level flag does not follow pin");
  a_fast_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.clk_ctl[tmr_pkg::BIT_FAST] && !st_r.clk_ctl[tmr_pkg::BIT_DBL0] && run_ok[0]
     && !st_r.mode[2]) |-> inc[0])
    else $error("fast timer 0 missed a clock");
  a_var_mask: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[1:0] == 2'b00 && inc[0] && !reg_wr)
    |=> ((st_r.cnt_lo[0] & ~(8'hff >> (3'h7 - $past(st_r.ctrl_b[2:0])))) == 8'h00))
    else $error("mode 0 low byte exceeds prescale width");
  a_run_keeps: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_wr && reg_addr == tmr_pkg::ADDR_CTRL && !inc[0]) |=> $stable(st_r.cnt_lo[0]))
    else $error("control write altered timer 0 count");
  a_r16_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[1:0] == 2'b01 && inc[0] && {st_r.cnt_hi[0], st_r.cnt_lo[0]} != 16'hffff
     && !reg_wr) |=> ({st_r.cnt_hi[0], st_r.cnt_lo[0]}
     == $past({st_r.cnt_hi[0], st_r.cnt_lo[0]}) + 16'h0001))
    else $error("mode 1 count did not step by one");
  a_pin_event: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st_r.mode[2] && run_ok[0] && tick[0])
    |-> (inc[0] == (st_r.pin_prev[0] && !cnt_sync_r[0])))
    else $error("counter step does not match pin fall");
  a_split_hi: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (split0 && st_r.ctrl[tmr_pkg::BIT_RUN1] && tick[0] && !reg_wr)
    |=> (st_r.cnt_hi[0] == $past(st_r.cnt_hi[0]) + 8'h01))
    else $error("split high byte did not count");
  a_split_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (split0 && !st_r.ctrl[tmr_pkg::BIT_OVF1] && !reg_wr
     && !(st_r.ctrl[tmr_pkg::BIT_RUN1] && tick[0] && st_r.cnt_hi[0] == 8'hff))
    |=> !st_r.ctrl[tmr_pkg::BIT_OVF1])
    else $error("timer 1 raised flag during split mode");

endmodule : dual_timer
`default_nettype wire

/* File: testbench/pin_model.sv */
// far-side model of the two counter pins
`default_nettype none
module pin_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] fall_go,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  output logic      [1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][4:0] low_cnt = '0;
  // low phase held 16 clocks, longer than any tick period used
  always @(posedge clk_sys) begin
    for (int n = 0; n < 2; n++) begin
      if (fall_go[n]) begin
        low_cnt[n] <= 5'h10;
      end else if (low_cnt[n] != 5'h00) begin
        low_cnt[n] <= low_cnt[n] - 5'h01;
      end
    end
  end
  // pull-up idle high; the block's own output wins while it drives
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      pin_in[n] = pin_oe_n[n] ? (low_cnt[n] == 5'h00) : pin_out[n];
    end
  end
endmodule : pin_model
`default_nettype wire

/* File: testbench/test_dual_timer.sv */
// self-checking bench of the dual timer
`default_nettype none
module test_dual_timer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [7:0] lo; logic [7:0] hi;} note_t;
  logic       clk_sys, reset_n, reg_wr, reg_rd, rd_d = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  logic [1:0] irq_ack, ext_irq_pin, pin_in, pin_out, oe_n, irq_req, fall_go;
  logic [31:0] seed;
  note_t      notes[$];
  note_t      cur;
  int         err_total = 0;
  int         n_checks = 0;
  logic [7:0] ck_cfg [4] = '{8'h05, 8'h10, 8'h25, 8'h35};
  logic [7:0] ck_exp [4] = '{8'd10, 8'd60, 8'd5, 8'd10};
  dual_timer i_dual_timer (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_ack(irq_ack), .ext_irq_pin(ext_irq_pin), .count_pin_in(pin_in),
    .count_pin_out(pin_out), .count_pin_oe_n(oe_n), .ext_irq_req(irq_req));
  pin_model i_pin_model (.clk_sys(clk_sys), .fall_go(fall_go), .pin_out(pin_out),
    .pin_oe_n(oe_n), .pin_in(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk_reg(input logic [7:0] a, seen, lo, hi);
    n_checks++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      err_total++;
      $display("wrong value reg_%h expected %h..%h seen %h", a, lo, hi, seen);
    end
  endtask : chk_reg
  task automatic chk_pin(input string nm, input logic [1:0] exp, seen);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk_pin
  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d === 1'b1) begin
      cur = notes.pop_front();
      chk_reg(cur.a, reg_rdata, cur.lo, cur.hi);
    end
    rd_d <= reg_rd;
  end
  task automatic wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd_rng(input logic [7:0] a, lo, hi);
    notes.push_back('{a, lo, hi});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd_rng
  task automatic rd(input logic [7:0] a, e);
    rd_rng(a, e, e);
  endtask : rd
  task automatic fall(input int n);
    fall_go[n] <= 1'b1;
    @(posedge clk_sys);
    fall_go <= 2'b00;
    repeat (40) @(posedge clk_sys);
  endtask : fall
  task automatic ack0;
    irq_ack <= 2'b01;
    @(posedge clk_sys);
    irq_ack <= 2'b00;
    @(posedge clk_sys);
  endtask : ack0
  task automatic rnd;
    seed = lfsr(seed);
    r = seed[7:0];
  endtask : rnd
  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, irq_ack, fall_go} = '0;
    ext_irq_pin = 2'b11;
    seed = 32'hf04d;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(tmr_pkg::ADDR_CTRL, 8'h00);
    rd(tmr_pkg::ADDR_MODE, 8'h00);
    rd(tmr_pkg::ADDR_CTRL_B, 8'h24);
    rd(tmr_pkg::ADDR_CLK_CTL, 8'h05);
    rd(8'h90, 8'h00);
    for (int a = 8'hf2; a <= 8'hf5; a++) rd(8'(a), 8'h00);
    for (int a = 8'hf2; a <= 8'hf5; a++) begin
      rnd();
      wr(8'(a), r);
      rd(8'(a), r);
    end
    $display("test reset and scratch done");
    wr(tmr_pkg::ADDR_MODE, 8'h05);
    wr(tmr_pkg::ADDR_CNT0_LO, 8'hff);
    wr(tmr_pkg::ADDR_CNT0_HI, 8'hff);
    rnd();
    wr(tmr_pkg::ADDR_RLD0_LO, r);
    wr(tmr_pkg::ADDR_RLD0_HI, 8'h5a);
    wr(tmr_pkg::ADDR_CTRL, 8'h10);
    rd(tmr_pkg::ADDR_CNT0_LO, 8'hff);
    fall(0);
    rd(tmr_pkg::ADDR_CNT0_LO, r);
    rd(tmr_pkg::ADDR_CNT0_HI, 8'h5a);
    rd(tmr_pkg::ADDR_CTRL, 8'h30);
    ack0();
    rd(tmr_pkg::ADDR_CTRL, 8'h10);
    wr(tmr_pkg::ADDR_MODE, 8'h0d);
    ext_irq_pin <= 2'b10;
    fall(0);
    rd(tmr_pkg::ADDR_CNT0_LO, r);
    chk_pin("irq_req", 2'b01, irq_req);
    ext_irq_pin <= 2'b11;
    fall(0);
    rd(tmr_pkg::ADDR_CNT0_LO, r + 8'h01);
    wr(tmr_pkg::ADDR_CTRL, 8'h00);
    fall(0);
    rd(tmr_pkg::ADDR_CNT0_LO, r + 8'h01);
    $display("test reload and gate done");
    wr(tmr_pkg::ADDR_MODE, 8'h06);
    wr(tmr_pkg::ADDR_CNT0_LO, 8'hff);
    rnd();
    wr(tmr_pkg::ADDR_CNT0_HI, r);
    wr(tmr_pkg::ADDR_CTRL, 8'h10);
    fall(0);
    rd(tmr_pkg::ADDR_CNT0_LO, r);
    rd(tmr_pkg::ADDR_CNT0_HI, r);
    rd(tmr_pkg::ADDR_CTRL, 8'h30);
    wr(tmr_pkg::ADDR_CTRL_B, 8'h20);
    wr(tmr_pkg::ADDR_MODE, 8'h04);
    wr(tmr_pkg::ADDR_CNT0_LO, 8'h01);
    wr(tmr_pkg::ADDR_CNT0_HI, 8'hff);
    wr(tmr_pkg::ADDR_CTRL, 8'h10);
    fall(0);
    rd(tmr_pkg::ADDR_CNT0_HI, 8'h00);
    rd(tmr_pkg::ADDR_CTRL, 8'h30);
    wr(tmr_pkg::ADDR_MODE, 8'h70);
    wr(tmr_pkg::ADDR_CNT1_LO, 8'h33);
    wr(tmr_pkg::ADDR_CTRL, 8'h40);
    fall(1);
    rd(tmr_pkg::ADDR_CNT1_LO, 8'h33);
    $display("test modes done");
    wr(tmr_pkg::ADDR_CTRL, 8'h01);
    ext_irq_pin <= 2'b10;
    repeat (5) @(posedge clk_sys);
    chk_pin("irq_req", 2'b01, irq_req);
    rd(tmr_pkg::ADDR_CTRL, 8'h03);
    ack0();
    ext_irq_pin <= 2'b11;
    rd(tmr_pkg::ADDR_CTRL, 8'h01);
    wr(tmr_pkg::ADDR_CTRL_B, 8'h64);
    chk_pin("oe_n", 2'b10, oe_n);
    wr(tmr_pkg::ADDR_RLD0_HI, 8'h00);
    wr(tmr_pkg::ADDR_RLD1_HI, 8'h00);
    chk_pin("pin_out", 2'b00, pin_out);
    wr(tmr_pkg::ADDR_RLD0_HI, 8'hff);
    chk_pin("pin_out", 2'b01, pin_out);
    chk_pin("pin_in", 2'b11, pin_in);
    wr(tmr_pkg::ADDR_CTRL_B, 8'h24);
    chk_pin("oe_n", 2'b11, oe_n);
    // tick rate seen as a count over a 60-clock run window
    for (int i = 0; i < 4; i++) begin
      wr(tmr_pkg::ADDR_CLK_CTL, ck_cfg[i]);
      wr(tmr_pkg::ADDR_MODE, 8'h01);
      wr(tmr_pkg::ADDR_CNT0_LO, 8'h00);
      wr(tmr_pkg::ADDR_CTRL, 8'h10);
      repeat (58) @(posedge clk_sys);
      wr(tmr_pkg::ADDR_CTRL, 8'h00);
      rd_rng(tmr_pkg::ADDR_CNT0_LO, ck_exp[i] - 8'd2, ck_exp[i] + 8'd1);
    end
    $display("test irq, output and rate done");
    // split mode: timer 0 high byte borrows timer 1 run bit and flag
    wr(tmr_pkg::ADDR_CLK_CTL, 8'h10);
    wr(tmr_pkg::ADDR_MODE, 8'h03);
    wr(tmr_pkg::ADDR_CNT1_LO, 8'h1f);
    wr(tmr_pkg::ADDR_CNT1_HI, 8'hff);
    wr(tmr_pkg::ADDR_CNT0_HI, 8'h00);
    wr(tmr_pkg::ADDR_CTRL, 8'h40);
    rd(tmr_pkg::ADDR_CNT1_HI, 8'h00);
    rd(tmr_pkg::ADDR_CTRL, 8'h40);
    wr(tmr_pkg::ADDR_CTRL, 8'h00);
    rd(tmr_pkg::ADDR_CNT0_HI, 8'h06);
    wr(tmr_pkg::ADDR_CNT0_HI, 8'hfa);
    wr(tmr_pkg::ADDR_CTRL, 8'h40);
    repeat (8) @(posedge clk_sys);
    rd(tmr_pkg::ADDR_CTRL, 8'hc0);
    $display("test split done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
endmodule : test_dual_timer
`default_nettype wire
